// File: verilog/cgsc_pkg.sv
`default_nettype none
package cgsc_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam int DIV_W  = 8;

  localparam logic [10:0] OFF_CTRL     = 11'h000;
  localparam logic [10:0] OFF_STATUS   = 11'h004;
  localparam logic [10:0] OFF_PHASE    = 11'h008;
  localparam logic [10:0] OFF_DIV_BASE = 11'h040;

  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_PD_BIT    = 1;

  localparam logic [DIV_W-1:0] DIV_RESET = 8'h04;
  localparam logic [DIV_W-1:0] DIV_MIN   = 8'h02;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_MHZ      = 125;
  localparam int LOCK_TIME_NS = 1000;
  localparam int LOCK_CYC     = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int STOP_TIME_NS = 200;
  localparam int STOP_CYC     = (STOP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int PS_TIME_NS   = 96;
  localparam int PS_CYC       = (PS_TIME_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic lost;
    logic ps_busy;
    logic div_done;
    logic halted;
    logic locked;
  } cgsc_status_t;
endpackage
`default_nettype wire

// File: verilog/cgsc_out_div.sv
`timescale 1ns/1ps
`default_nettype none
module cgsc_out_div #(
  parameter int DIV_W = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset,
  input  wire logic             i_hold,
  input  wire logic             i_run,
  input  wire logic [DIV_W-1:0] i_div,
  input  wire logic             i_load,
  input  wire logic             i_slip,
  input  wire logic             i_skip,
  output logic                  o_clk,
  output logic                  o_loaded
);
  logic [DIV_W-1:0] div_act;
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] last;
  logic [DIV_W-1:0] div_safe;
  logic             wrap;

  assign div_safe = (i_div < DIV_W'(2)) ? DIV_W'(2) : i_div;
  assign last     = div_act - DIV_W'(1);
  assign wrap     = (cnt >= last);

  // New divide taken only at a period boundary or while stopped or held, so no runt pulse escapes
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_hold) begin
      div_act  <= div_safe;
      o_loaded <= 1'b0;
    end else if (!i_load) begin
      o_loaded <= 1'b0;
    end else if ((wrap || !i_run) && !o_loaded) begin
      div_act  <= div_safe;
      o_loaded <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_hold || !i_run) begin
      cnt <= '0;
    end else if (i_slip) begin
      cnt <= cnt;
    end else if (i_skip) begin
      if (wrap) begin
        cnt <= DIV_W'(1);
      end else if (cnt + DIV_W'(1) == last) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + DIV_W'(2);
      end
    end else if (wrap) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset || i_hold || !i_run) begin
      o_clk <= 1'b0;
    end else begin
      o_clk <= (cnt < (div_act >> 1));
    end
  end
endmodule
`default_nettype wire

// File: verilog/cgsc_top.sv
`timescale 1ns/1ps
`default_nettype none
module cgsc_top #(
  parameter int N_OUT          = 4,
  parameter bit RESET_ACT_LOW  = 1'b0,
  parameter bit DIFF_INPUT     = 1'b0,
  parameter bit SPREAD_SPECTRUM = 1'b0,
  parameter bit LIVE_UPDATE_EN = 1'b1,
  parameter bit EN_RESET       = 1'b1,
  parameter bit EN_POWER_DOWN  = 1'b1,
  parameter bit EN_HALTED      = 1'b1,
  parameter bit EN_LOCKED      = 1'b1,
  parameter bit EN_PHASE_SHIFT = 1'b1
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_reset,
  input  wire logic                       i_primary_input_clock,
  input  wire logic                       i_primary_input_clock_n,
  input  wire logic                       i_prim_reset,
  input  wire logic                       i_power_down,
  input  wire logic                       i_ps_en,
  input  wire logic                       i_ps_inc,
  input  wire logic                       i_div_chg_req,
  input  wire logic [cgsc_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic [cgsc_pkg::DATA_W-1:0] i_reg_wdata,
  input  wire logic [cgsc_pkg::BE_W-1:0]   i_reg_be,
  input  wire logic                       i_reg_wr,
  input  wire logic                       i_reg_rd,
  output logic      [cgsc_pkg::DATA_W-1:0] o_reg_rdata,
  output logic      [1:0]                 o_reg_resp,
  output logic      [N_OUT-1:0]           o_clk_out,
  output logic                            o_locked,
  output logic                            o_src_halted,
  output logic                            o_ps_done,
  output logic                            o_div_chg_done
);
  localparam int LOCK_W  = $clog2(cgsc_pkg::LOCK_CYC + 1);
  localparam int STOP_W  = $clog2(cgsc_pkg::STOP_CYC + 1);
  localparam int PS_W    = $clog2(cgsc_pkg::PS_CYC + 1);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(cgsc_pkg::LOCK_CYC);
  localparam logic [STOP_W-1:0] STOP_LAST = STOP_W'(cgsc_pkg::STOP_CYC);
  localparam logic [PS_W-1:0]   PS_LAST   = PS_W'(cgsc_pkg::PS_CYC);
  localparam int IDX_W   = (N_OUT > 1) ? $clog2(N_OUT) : 1;

  cgsc_pkg::cgsc_status_t status;

  logic                         ctrl_sw_reset;
  logic                         ctrl_pd;
  logic [cgsc_pkg::DIV_W-1:0]   div_cfg [N_OUT];
  logic                         prim_clear;
  logic                         rst_meta;
  logic                         rst_hold;
  logic                         prim_hold;
  logic                         pd_meta;
  logic                         pd_sync;
  logic                         pd_act;
  logic                         src_meta;
  logic                         src_sync;
  logic                         src_prev;
  logic                         neg_meta;
  logic                         neg_sync;
  logic [STOP_W-1:0]            idle_cnt;
  logic                         halted;
  logic [LOCK_W-1:0]            lock_cnt;
  logic                         locked_int;
  logic                         lost;
  logic                         ps_busy;
  logic [PS_W-1:0]              ps_cnt;
  logic                         ps_dir;
  logic                         ps_apply;
  logic signed [15:0]           phase_pos;
  logic                         req_q;
  logic                         chg_pend;
  logic [N_OUT-1:0]             ch_loaded;
  logic [N_OUT-1:0]             ch_clk;
  logic                         run;
  logic                         src_level;
  logic                         addr_ok;
  logic                         is_div;
  logic [3:0]                   div_idx;
  logic [IDX_W-1:0]             div_sel;
  logic [cgsc_pkg::DATA_W-1:0]  next_rdata;
  logic [1:0]                   next_resp;

  // Software reset and the pin share one asynchronous clear
  // Polarity folded once so both settings clear identically
  assign prim_clear = ctrl_sw_reset |
    (EN_RESET & (RESET_ACT_LOW ? ~i_prim_reset : i_prim_reset));

  // Asserts at once, releases two edges after the pin drops
  always_ff @(posedge i_clk_sys or posedge prim_clear) begin
    if (prim_clear) begin
      rst_meta <= 1'b1;
      rst_hold <= 1'b1;
    end else begin
      rst_meta <= 1'b0;
      rst_hold <= rst_meta;
    end
  end
  assign prim_hold = rst_hold | i_reset;

  // Each leg synchronised on its own before any logic combines them
  always_ff @(posedge i_clk_sys) begin
    pd_meta  <= i_power_down;
    pd_sync  <= pd_meta;
    src_meta <= i_primary_input_clock;
    src_sync <= src_meta;
    neg_meta <= i_primary_input_clock_n;
    neg_sync <= neg_meta;
    src_prev <= src_level;
  end
  assign pd_act    = (EN_POWER_DOWN & pd_sync) | ctrl_pd;
  assign src_level = DIFF_INPUT ? (src_sync & ~neg_sync) : src_sync;

  // Activity watch: no edge for the stop window means the source halted
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || src_level != src_prev) begin
      idle_cnt <= '0;
    end else if (idle_cnt != STOP_LAST) begin
      idle_cnt <= idle_cnt + STOP_W'(1);
    end
  end
  assign halted = (idle_cnt == STOP_LAST);

  // Lock sequence; a lost source stays lost until a fresh reset
  always_ff @(posedge i_clk_sys or posedge prim_clear) begin
    if (prim_clear) begin
      lock_cnt <= '0;
      lost     <= 1'b0;
    end else if (prim_hold) begin
      lock_cnt <= '0;
      lost     <= 1'b0;
    end else if (pd_act) begin
      lock_cnt <= '0;
    end else if (halted) begin
      lock_cnt <= '0;
      lost     <= 1'b1;
    end else if (!lost && lock_cnt != LOCK_LAST) begin
      lock_cnt <= lock_cnt + LOCK_W'(1);
    end
  end
  assign locked_int = (lock_cnt == LOCK_LAST) && !lost && !halted &&
                      !pd_act && !prim_hold;
  assign run = !pd_act && !prim_hold && !halted;

  // Registered so downstream logic sees clean levels
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_locked     <= 1'b0;
      o_src_halted <= 1'b0;
    end else begin
      o_locked     <= EN_LOCKED & locked_int;
      o_src_halted <= EN_HALTED & halted;
    end
  end

  // Phase step: accepted only while locked and idle
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || prim_hold) begin
      ps_busy   <= 1'b0;
      ps_cnt    <= '0;
      ps_dir    <= 1'b0;
      o_ps_done <= 1'b0;
      phase_pos <= 16'sh0000;
    end else begin
      o_ps_done <= 1'b0;
      if (!ps_busy) begin
        if (EN_PHASE_SHIFT && i_ps_en && locked_int) begin
          ps_busy <= 1'b1;
          ps_cnt  <= '0;
          ps_dir  <= i_ps_inc;
        end
      end else if (ps_cnt == PS_LAST - PS_W'(1)) begin
        ps_busy   <= 1'b0;
        o_ps_done <= 1'b1;
        phase_pos <= ps_dir ? phase_pos + 16'sh0001 : phase_pos - 16'sh0001;
      end else begin
        ps_cnt <= ps_cnt + PS_W'(1);
      end
    end
  end
  assign ps_apply = ps_busy && (ps_cnt == PS_LAST - PS_W'(1));

  // Live divider change handshake
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      req_q    <= 1'b0;
      chg_pend <= 1'b0;
    end else begin
      req_q <= i_div_chg_req;
      if (!i_div_chg_req) begin
        chg_pend <= 1'b0;
      end else if (!req_q && LIVE_UPDATE_EN) begin
        chg_pend <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_div_chg_done <= 1'b0;
    end else begin
      o_div_chg_done <= chg_pend && (&ch_loaded);
    end
  end

  // Control bits live in byte lane 0; other lanes ignored
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ctrl_sw_reset <= 1'b0;
      ctrl_pd       <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == cgsc_pkg::OFF_CTRL &&
                 i_reg_be[0]) begin
      ctrl_sw_reset <= i_reg_wdata[cgsc_pkg::CTRL_RESET_BIT];
      ctrl_pd       <= i_reg_wdata[cgsc_pkg::CTRL_PD_BIT];
    end
  end

  // One divide word per output, upward from the divider base
  assign is_div  = (i_reg_addr[10:6] == cgsc_pkg::OFF_DIV_BASE[10:6]) &&
                   (i_reg_addr[1:0] == 2'h0) &&
                   (32'(i_reg_addr[5:2]) < N_OUT);
  assign div_idx = i_reg_addr[5:2];
  assign div_sel = div_idx[IDX_W-1:0];

  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_ch
      localparam bit CH_ON = !(SPREAD_SPECTRUM && (g == 2 || g == 3));
      always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
          div_cfg[g] <= cgsc_pkg::DIV_RESET;
        end else if (i_reg_wr && is_div && div_idx == 4'(g) &&
                     i_reg_be[0]) begin
          div_cfg[g] <= i_reg_wdata[cgsc_pkg::DIV_W-1:0];
        end
      end

      cgsc_out_div #(
        .DIV_W (cgsc_pkg::DIV_W)
      ) u_div (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_hold    (prim_hold),
        .i_run     (run && CH_ON),
        .i_div     (div_cfg[g]),
        .i_load    (chg_pend),
        // Increase holds one count, decrease skips one
        .i_slip    (ps_apply && ps_dir),
        .i_skip    (ps_apply && !ps_dir),
        .o_clk     (ch_clk[g]),
        .o_loaded  (ch_loaded[g])
      );
      // Spread spectrum drops the third and fourth outputs
      assign o_clk_out[g] = CH_ON ? ch_clk[g] : 1'b0;
    end
  endgenerate

  // Status word shows the raw lock, not the registered pin
  assign status.lost     = lost;
  assign status.ps_busy  = ps_busy;
  assign status.div_done = o_div_chg_done;
  assign status.halted   = halted;
  assign status.locked   = locked_int;

  always_comb begin
    next_rdata = 32'h0000_0000;
    addr_ok    = 1'b1;
    if (i_reg_addr == cgsc_pkg::OFF_CTRL) begin
      next_rdata[cgsc_pkg::CTRL_RESET_BIT] = ctrl_sw_reset;
      next_rdata[cgsc_pkg::CTRL_PD_BIT]    = ctrl_pd;
    end else if (i_reg_addr == cgsc_pkg::OFF_STATUS) begin
      next_rdata[$bits(status)-1:0] = status;
      addr_ok = !i_reg_wr;
    end else if (i_reg_addr == cgsc_pkg::OFF_PHASE) begin
      next_rdata[15:0] = phase_pos;
      addr_ok = !i_reg_wr;
    end else if (is_div) begin
      next_rdata[cgsc_pkg::DIV_W-1:0] = div_cfg[div_sel];
    end else begin
      addr_ok = 1'b0;
    end
    // Only okay or slave error; decode error never produced
    next_resp = addr_ok ? cgsc_pkg::RESP_OKAY
                        : cgsc_pkg::RESP_SLVERR;
  end

  // Answer stands one cycle; an idle bus shows zero and okay
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_reg_rdata <= 32'h0000_0000;
      o_reg_resp  <= cgsc_pkg::RESP_OKAY;
    end else begin
      o_reg_rdata <= i_reg_rd ? next_rdata : 32'h0000_0000;
      o_reg_resp  <= (i_reg_rd || i_reg_wr) ? next_resp
                                            : cgsc_pkg::RESP_OKAY;
    end
  end
endmodule
`default_nettype wire

// File: verif/cgsc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module cgsc_far_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_run,
  input  wire logic       i_out0,
  output logic            o_src_clk,
  output logic      [7:0] o_hi_len
);
  logic [7:0] cnt = 8'h00;

  // Source clock stands still while not running
  initial begin
    o_src_clk = 1'b0;
    forever begin
      #20;
      if (i_run) o_src_clk = ~o_src_clk;
    end
  end

  // Consumer keeps the length of the last high phase
  initial o_hi_len = 8'h00;
  always @(posedge i_clk_sys) begin
    if (i_out0) begin
      cnt <= cnt + 8'h01;
    end else begin
      if (cnt != 8'h00) o_hi_len <= cnt;
      cnt <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// File: verif/cgsc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cgsc_chk #(
  parameter int N_OUT = 4
) (
  input wire logic             i_clk_sys,
  input wire logic             i_reset,
  input wire logic             i_prim_reset,
  input wire logic             i_power_down,
  input wire logic             i_div_chg_req,
  input wire logic             i_reg_wr,
  input wire logic             i_reg_rd,
  input wire logic [31:0]      o_reg_rdata,
  input wire logic [1:0]       o_reg_resp,
  input wire logic [N_OUT-1:0] o_clk_out,
  input wire logic             o_locked,
  input wire logic             o_ps_done,
  input wire logic             o_div_chg_done
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  a_no_decode_err: assert property (o_reg_resp != 2'h3)
    else $error("decode error code seen");
  a_resp_idle_okay: assert property (!(i_reg_wr || i_reg_rd) |=>
    o_reg_resp == cgsc_pkg::RESP_OKAY) else $error("resp without access");
  a_rdata_idle_zero: assert property (!i_reg_rd |=>
    o_reg_rdata == 32'h0000_0000) else $error("rdata without read");
  a_ps_done_pulse: assert property (o_ps_done |=> !o_ps_done)
    else $error("phase done longer than one cycle");
  a_pd_unlocks: assert property (i_power_down [*6] |-> !o_locked)
    else $error("locked during power down");
  a_pd_clk_stop: assert property (i_power_down [*6] |=>
    $stable(o_clk_out)) else $error("clocks toggle in power down");
  a_prim_unlocks: assert property (i_prim_reset [*2] |-> !o_locked)
    else $error("locked during primitive reset");
  a_relock_wait: assert property ($fell(i_prim_reset) |->
    !o_locked [*8]) else $error("lock too early after reset");
  a_div_done_drop: assert property ($fell(i_div_chg_req) |->
    ##3 !o_div_chg_done) else $error("divider done stuck");
  a_div_done_cause: assert property (o_div_chg_done |->
    $past(i_div_chg_req, 2)) else $error("divider done without request");

  c_ps_done: cover property (o_ps_done);
  c_div_done: cover property ($rose(o_div_chg_done));
  c_relock: cover property ($rose(o_locked));
endmodule

bind cgsc_top cgsc_chk #(.N_OUT(N_OUT)) u_chk (
  .i_clk_sys, .i_reset, .i_prim_reset, .i_power_down, .i_div_chg_req,
  .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_resp, .o_clk_out,
  .o_locked, .o_ps_done, .o_div_chg_done
);
`default_nettype wire

// File: verif/cgsc_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cgsc_top_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        run = 1'b1;
  logic        src_clk;
  logic        prim = 1'b0;
  logic        pd = 1'b0;
  logic        ps_en = 1'b0;
  logic        ps_inc = 1'b0;
  logic        div_req = 1'b0;
  logic [10:0] addr = 11'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  be = 4'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0]  resp;
  logic [3:0]  clk_out;
  logic        locked;
  logic        halted;
  logic        ps_done;
  logic        div_done;
  logic [7:0]  hi_len;
  logic [3:0]  held;
  int          err_count = 0;
  int          num_checks = 0;

  initial forever #4 clk = ~clk;

  cgsc_top DUT (
    .i_clk_sys(clk), .i_reset(rst), .i_primary_input_clock(src_clk),
    .i_primary_input_clock_n(1'b0), .i_prim_reset(prim),
    .i_power_down(pd), .i_ps_en(ps_en), .i_ps_inc(ps_inc),
    .i_div_chg_req(div_req), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_be(be), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .o_reg_resp(resp), .o_clk_out(clk_out), .o_locked(locked),
    .o_src_halted(halted), .o_ps_done(ps_done),
    .o_div_chg_done(div_done)
  );

  cgsc_far_model u_far (
    .i_clk_sys(clk), .i_run(run), .i_out0(clk_out[0]),
    .o_src_clk(src_clk), .o_hi_len(hi_len)
  );

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [10:0] a, input logic [31:0] d,
                        input logic [3:0] b, input logic [1:0] er);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1 check({30'h0, resp}, {30'h0, er});
  endtask

  task automatic reg_rd(input logic [10:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, ed);
    check({30'h0, resp}, {30'h0, er});
  endtask

  // Bounded wait; running out ends the run
  task automatic wait_on(input int sel, input logic v, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? locked : sel == 1 ? halted : div_done) !== v
           && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= lim) begin
      err_count++;
      end_of_test();
    end
  endtask

  task automatic step(input logic inc);
    @(posedge clk);
    ps_en <= 1'b1;
    ps_inc <= inc;
    @(posedge clk);
    ps_en <= 1'b0;
    repeat (11) @(posedge clk);
    #1 check({31'h0, ps_done}, 32'h0000_0000);
    @(posedge clk);
    #1 check({31'h0, ps_done}, 32'h0000_0001);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wait_on(0, 1'b1, 300);
    reg_rd(cgsc_pkg::OFF_STATUS, 32'h0000_0001, 2'h0);
    reg_rd(cgsc_pkg::OFF_CTRL, 32'h0000_0000, 2'h0);
    for (int i = 0; i < 4; i++) begin
      reg_rd(cgsc_pkg::OFF_DIV_BASE + 11'(4 * i),
             32'h0000_0004, 2'h0);
    end
    check({24'h0, hi_len}, 32'h0000_0002);
    reg_rd(11'h7fc, 32'h0000_0000, 2'h2);
    reg_wr(cgsc_pkg::OFF_STATUS, 32'h0000_0001, 4'hf, 2'h2);
    reg_wr(11'h044, 32'h0000_0009, 4'he, 2'h0);
    reg_rd(11'h044, 32'h0000_0004, 2'h0);
    reg_wr(11'h044, 32'hffff_ff09, 4'h1, 2'h0);
    reg_rd(11'h044, 32'h0000_0009, 2'h0);
    step(1'b1);
    reg_rd(cgsc_pkg::OFF_PHASE, 32'h0000_0001, 2'h0);
    step(1'b0);
    reg_rd(cgsc_pkg::OFF_PHASE, 32'h0000_0000, 2'h0);
    reg_wr(cgsc_pkg::OFF_DIV_BASE, 32'h0000_0006, 4'h1, 2'h0);
    @(posedge clk);
    div_req <= 1'b1;
    wait_on(2, 1'b1, 40);
    repeat (20) @(posedge clk);
    #1 check({24'h0, hi_len}, 32'h0000_0003);
    check({31'h0, locked}, 32'h0000_0001);
    @(posedge clk);
    div_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1 check({31'h0, div_done}, 32'h0000_0000);
    @(posedge clk);
    pd <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check({31'h0, locked}, 32'h0000_0000);
    held = clk_out;
    repeat (6) begin
      @(posedge clk);
      #1 check({28'h0, clk_out}, {28'h0, held});
    end
    @(posedge clk);
    pd <= 1'b0;
    wait_on(0, 1'b1, 300);
    @(posedge clk);
    prim <= 1'b1;
    @(posedge clk);
    #1 check({31'h0, locked}, 32'h0000_0000);
    @(posedge clk);
    prim <= 1'b0;
    repeat (8) @(posedge clk);
    #1 check({31'h0, locked}, 32'h0000_0000);
    wait_on(0, 1'b1, 300);
    run <= 1'b0;
    wait_on(1, 1'b1, 60);
    check({31'h0, locked}, 32'h0000_0000);
    run <= 1'b1;
    wait_on(1, 1'b0, 60);
    @(posedge clk);
    prim <= 1'b1;
    @(posedge clk);
    prim <= 1'b0;
    wait_on(0, 1'b1, 300);
    end_of_test();
  end
endmodule
`default_nettype wire
